// ===== design/wdt_pkg.sv
// Notes on behaviour
// [RQ1] reset loads control with zero: watchdog on, clock divided by 4096
// [RQ2] watchdog reset disabled only while control bits 7..4 hold 1010
// [RQ3] writing one to control bit 1 clears the tick counter
// [RQ4] writing one to control bit 0 clears both prescalers, pulsed out
// [RQ5] counter clock selects oscillator divided by 4096, 1024 or 128
// [RQ6] enabled watchdog: bit 7 overflow asserts overflow and system reset
// [RQ7] tick counter readable at its address, software writes ignored
// [RQ8] software clears the counter often enough to avoid overflow
// [RQ9] stop release counts at 4096 after reset, preset clock after interrupt
// [RQ10] counter bit 7 set in stabilization releases the cpu clock
// [RQ11] select code zero is 4096, one is 1024, two is 128
package wdt_pkg;
  localparam logic [7:0] ADDR_CONTROL = 8'hd3;
  localparam logic [7:0] ADDR_COUNT = 8'hfd;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [3:0] KEY_DISABLE = 4'ha;
  localparam int KEY_HI = 7;
  localparam int KEY_LO = 4;
  localparam int SEL_HI = 3;
  localparam int SEL_LO = 2;
  localparam int BIT_CNT_CLR = 1;
  localparam int BIT_DIV_CLR = 0;
  localparam int BIT_TOP = 7;
  localparam int DIV_W = 12;
  localparam logic [1:0] SEL_4096 = 2'h0;
  localparam logic [1:0] SEL_1024 = 2'h1;
  localparam logic [1:0] SEL_128 = 2'h2;
  localparam int TAP_4096 = 11;
  localparam int TAP_1024 = 9;
  localparam int TAP_128 = 6;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;
  typedef enum logic [2:0] {
    ST_RUN = 3'h1,
    ST_STOP = 3'h2,
    ST_STAB = 3'h4
  } mode_t;
endpackage

// ===== design/tick_prescaler.sv
`timescale 1ns/10ps
`default_nettype none
module tick_prescaler
  import wdt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clear,
  input wire logic run,
  input wire logic [1:0] sel,
  output logic tick
);
  logic [DIV_W-1:0] div_r;
  logic [DIV_W-1:0] div_nxt;
  logic tap;

  always_comb begin
    div_nxt = div_r + {{(DIV_W-1){1'b0}}, 1'b1};
    unique case (sel)
      SEL_1024: tap = div_nxt[TAP_1024] & ~div_r[TAP_1024];
      SEL_128: tap = div_nxt[TAP_128] & ~div_r[TAP_128];
      default: tap = div_nxt[TAP_4096] & ~div_r[TAP_4096];
    endcase
  end

  // divider with rising-edge tap gives one pulse per period
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      div_r <= '0;
    end else if (clear) begin
      div_r <= '0; // RQ4
    end else if (run) begin
      div_r <= div_nxt;
    end
  end

  assign tick = run & ~clear & tap; // RQ5 RQ11
endmodule
`default_nettype wire

// ===== design/basic_watchdog_stabilizer.sv
`timescale 1ns/10ps
`default_nettype none
module basic_watchdog_stabilizer
  import wdt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire bus_req_t bus_req,
  input wire logic stop_req,
  input wire logic wake_irq,
  output logic [7:0] rdata,
  output logic tick_overflow,
  output logic sys_reset_req,
  output logic div_clear,
  output logic cpu_clk_en,
  output logic stab_done
);
  logic [7:0] ctrl_r;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic cnt_clr_r;
  logic stab_rst_r;
  mode_t mode_r;
  logic tick;
  logic wr_ctrl;
  logic wd_on;
  logic [1:0] eff_sel;
  logic run;
  logic ovf;
  logic wake_m_r;
  logic wake_s_r;
  logic wake_q_r;
  logic wake_ok;

  // wake pin passes three flops; a level counts once the last two agree
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wake_m_r <= 1'b0;
      wake_s_r <= 1'b0;
      wake_q_r <= 1'b0;
    end else begin
      wake_m_r <= wake_irq;
      wake_s_r <= wake_m_r;
      wake_q_r <= wake_s_r;
    end
  end

  assign wake_ok = wake_s_r & wake_q_r;

  assign wr_ctrl = bus_req.wr && bus_req.addr == ADDR_CONTROL;
  assign wd_on = ctrl_r[KEY_HI:KEY_LO] != KEY_DISABLE; // RQ2
  assign eff_sel = stab_rst_r ? SEL_4096 : ctrl_r[SEL_HI:SEL_LO]; // RQ9
  assign run = mode_r != ST_STOP;
  assign cnt_nxt = cnt_r + 8'h01;
  assign ovf = tick && cnt_r == 8'hff;

  tick_prescaler u_pre (
    .clk_sys(clk_sys),
    .reset(reset),
    .clear(wr_ctrl && bus_req.wdata[BIT_DIV_CLR]),
    .run(run),
    .sel(eff_sel),
    .tick(tick)
  );

  // control: clear bits act as strobes, not stored
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ctrl_r <= CONTROL_RESET; // RQ1
    end else if (wr_ctrl) begin
      ctrl_r <= {bus_req.wdata[7:2], 2'b00};
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      div_clear <= 1'b0;
    end else begin
      div_clear <= wr_ctrl && bus_req.wdata[BIT_DIV_CLR]; // RQ4
    end
  end

  assign cnt_clr_r = wr_ctrl && bus_req.wdata[BIT_CNT_CLR];

  // tick counter, read-only to software
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cnt_r <= 8'h00;
    end else if (cnt_clr_r || (mode_r == ST_RUN && stop_req)) begin
      cnt_r <= 8'h00; // RQ3
    end else if (mode_r == ST_STOP && wake_ok) begin
      cnt_r <= 8'h00;
    end else if (tick) begin
      cnt_r <= cnt_nxt; // RQ7
    end
  end

  // stop / stabilization sequencing
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      mode_r <= ST_STAB; // RQ9
      stab_rst_r <= 1'b1;
    end else begin
      unique case (mode_r)
        ST_RUN: if (stop_req) mode_r <= ST_STOP;
        ST_STOP: if (wake_ok) begin
          mode_r <= ST_STAB; // RQ9
          stab_rst_r <= 1'b0;
        end
        ST_STAB: if (cnt_r[BIT_TOP]) begin
          mode_r <= ST_RUN; // RQ10
          stab_rst_r <= 1'b0;
        end
        default: mode_r <= ST_RUN;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cpu_clk_en <= 1'b0;
      stab_done <= 1'b0;
    end else begin
      cpu_clk_en <= mode_r == ST_RUN ||
                    (mode_r == ST_STAB && cnt_r[BIT_TOP]); // RQ10
      stab_done <= mode_r == ST_STAB && cnt_r[BIT_TOP]; // RQ10
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tick_overflow <= 1'b0;
      sys_reset_req <= 1'b0;
    end else begin
      tick_overflow <= ovf && mode_r == ST_RUN; // RQ6
      sys_reset_req <= ovf && mode_r == ST_RUN && wd_on; // RQ6
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rdata <= 8'h00;
    end else if (bus_req.rd) begin
      unique case (bus_req.addr)
        ADDR_CONTROL: rdata <= ctrl_r;
        ADDR_COUNT: rdata <= cnt_r; // RQ7
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  AST_WD_RESET: assert property (@(posedge clk_sys) disable iff (reset) // RQ6
    (ovf && mode_r == ST_RUN && wd_on)
    |=> sys_reset_req)
    else $error("overflow did not reset");

  AST_KEY_OFF: assert property (@(posedge clk_sys) disable iff (reset) // RQ2
    (ctrl_r[KEY_HI:KEY_LO] == KEY_DISABLE)
    |=> !sys_reset_req)
    else $error("reset while disabled");

  AST_CNT_CLR: assert property (@(posedge clk_sys) disable iff (reset) // RQ3
    cnt_clr_r
    |=> cnt_r == 8'h00)
    else $error("counter not cleared");

  AST_DIV_CLR: assert property (@(posedge clk_sys) disable iff (reset) // RQ4
    (wr_ctrl && bus_req.wdata[BIT_DIV_CLR])
    |=> div_clear)
    else $error("divider clear missing");

  AST_RD_CNT: assert property (@(posedge clk_sys) disable iff (reset) // RQ7
    (bus_req.rd && bus_req.addr == ADDR_COUNT)
    |=> rdata == $past(cnt_r))
    else $error("count read wrong");

  AST_RELEASE: assert property (@(posedge clk_sys) disable iff (reset) // RQ10
    (mode_r == ST_STAB && cnt_r[BIT_TOP])
    |=> stab_done && cpu_clk_en)
    else $error("no release");

  AST_RST_RATE: assert property (@(posedge clk_sys) disable iff (reset) // RQ9
    stab_rst_r
    |-> eff_sel == SEL_4096)
    else $error("reset rate wrong");

  AST_CTRL_WR: assert property (@(posedge clk_sys) disable iff (reset) // RQ1
    wr_ctrl
    |=> ctrl_r[7:2] == $past(bus_req.wdata[7:2]))
    else $error("control not written");

  AST_CTRL_LOW: assert property (@(posedge clk_sys) disable iff (reset) // RQ3
    wr_ctrl
    |=> ctrl_r[1:0] == 2'h0)
    else $error("strobe bits stored");

  AST_RST_KEY: assert property (@(posedge clk_sys) disable iff (reset) // RQ2
    sys_reset_req
    |-> $past(wd_on))
    else $error("reset with key set");

  AST_WDOFF_QUIET: assert property (@(posedge clk_sys) disable iff (reset) // RQ2
    !wd_on
    |=> !sys_reset_req)
    else $error("reset while watchdog off");

  AST_OVF_SRC: assert property (@(posedge clk_sys) disable iff (reset) // RQ6
    tick_overflow
    |-> $past(cnt_r) == 8'hff)
    else $error("overflow without full count");

  AST_OVF_WRAP: assert property (@(posedge clk_sys) disable iff (reset) // RQ6
    (ovf && !cnt_clr_r && mode_r == ST_RUN)
    |=> cnt_r == 8'h00)
    else $error("counter did not wrap");

  AST_RST_OVF: assert property (@(posedge clk_sys) disable iff (reset) // RQ6
    sys_reset_req
    |-> tick_overflow)
    else $error("reset without overflow");

  AST_OVF_RUN: assert property (@(posedge clk_sys) disable iff (reset) // RQ6
    tick_overflow
    |-> $past(mode_r) == ST_RUN)
    else $error("overflow outside run");

  AST_NO_OVF_IDLE: assert property (@(posedge clk_sys) disable iff (reset) // RQ6
    mode_r != ST_RUN
    |=> !tick_overflow)
    else $error("overflow while not running");

  AST_OVF_PULSE: assert property (@(posedge clk_sys) disable iff (reset) // RQ6
    tick_overflow
    |=> !tick_overflow)
    else $error("overflow longer than a cycle");

  AST_CNT_HOLD: assert property (@(posedge clk_sys) disable iff (reset) // RQ7
    (!tick && !cnt_clr_r && !(mode_r == ST_RUN && stop_req)
      && !(mode_r == ST_STOP && wake_ok))
    |=> $stable(cnt_r))
    else $error("counter moved without tick");

  AST_CNT_STEP: assert property (@(posedge clk_sys) disable iff (reset) // RQ5
    (tick && !cnt_clr_r && !(mode_r == ST_RUN && stop_req))
    |=> cnt_r == $past(cnt_r) + 8'h01)
    else $error("counter did not step");

  AST_CNT_WR_IGN: assert property (@(posedge clk_sys) disable iff (reset) // RQ7
    (bus_req.wr && bus_req.addr == ADDR_COUNT && !tick && !stop_req)
    |=> $stable(cnt_r))
    else $error("counter took a write");

  AST_DIV_ONLY: assert property (@(posedge clk_sys) disable iff (reset) // RQ4
    div_clear
    |-> $past(wr_ctrl))
    else $error("divider clear without write");

  AST_DIV_IDLE: assert property (@(posedge clk_sys) disable iff (reset) // RQ4
    !(wr_ctrl && bus_req.wdata[BIT_DIV_CLR])
    |=> !div_clear)
    else $error("spurious divider clear");

  AST_TICK_CLR: assert property (@(posedge clk_sys) disable iff (reset) // RQ4
    (wr_ctrl && bus_req.wdata[BIT_DIV_CLR])
    |-> !tick)
    else $error("tick during divider clear");

  AST_STOP_TICK: assert property (@(posedge clk_sys) disable iff (reset) // RQ9
    mode_r == ST_STOP
    |-> !tick)
    else $error("tick in stop");

  AST_STOP_CPU: assert property (@(posedge clk_sys) disable iff (reset) // RQ9
    mode_r == ST_STOP
    |=> !cpu_clk_en)
    else $error("cpu clock in stop");

  AST_STAB_CPU: assert property (@(posedge clk_sys) disable iff (reset) // RQ10
    (mode_r == ST_STAB && !cnt_r[BIT_TOP])
    |=> !cpu_clk_en)
    else $error("cpu clock before stable");

  AST_RUN_CPU: assert property (@(posedge clk_sys) disable iff (reset) // RQ10
    mode_r == ST_RUN
    |=> cpu_clk_en)
    else $error("cpu clock off in run");

  AST_STAB_EXIT: assert property (@(posedge clk_sys) disable iff (reset) // RQ10
    (mode_r == ST_STAB && cnt_r[BIT_TOP])
    |=> mode_r == ST_RUN)
    else $error("stabilization not left");

  AST_WAKE: assert property (@(posedge clk_sys) disable iff (reset) // RQ9
    (mode_r == ST_STOP && wake_ok)
    |=> mode_r == ST_STAB && cnt_r == 8'h00 && !stab_rst_r)
    else $error("wake not taken");

  AST_STOP_ENTRY: assert property (@(posedge clk_sys) disable iff (reset) // RQ9
    (mode_r == ST_RUN && stop_req)
    |=> mode_r == ST_STOP && cnt_r == 8'h00)
    else $error("stop not entered");

  AST_STOP_HOLD: assert property (@(posedge clk_sys) disable iff (reset) // RQ9
    (mode_r == ST_STOP && !wake_ok)
    |=> mode_r == ST_STOP)
    else $error("stop left without wake");

  AST_MODE_ONEHOT: assert property (@(posedge clk_sys) disable iff (reset) // RQ10
    1'b1
    |-> $onehot(mode_r))
    else $error("mode code illegal");

  AST_RST_STAB: assert property (@(posedge clk_sys) disable iff (reset) // RQ9
    stab_rst_r
    |-> mode_r == ST_STAB)
    else $error("reset rate outside stabilization");

  AST_SEL_USER: assert property (@(posedge clk_sys) disable iff (reset) // RQ11
    !stab_rst_r
    |-> eff_sel == ctrl_r[SEL_HI:SEL_LO])
    else $error("select not from control");

  AST_RD_CTRL: assert property (@(posedge clk_sys) disable iff (reset) // RQ1
    (bus_req.rd && bus_req.addr == ADDR_CONTROL)
    |=> rdata == $past(ctrl_r))
    else $error("control read wrong");

  AST_RD_IDLE: assert property (@(posedge clk_sys) disable iff (reset) // RQ7
    !bus_req.rd
    |=> rdata == 8'h00)
    else $error("read data without read");

  AST_DONE_PULSE: assert property (@(posedge clk_sys) disable iff (reset) // RQ10
    stab_done
    |=> !stab_done)
    else $error("done longer than a cycle");

  AST_DONE_CPU: assert property (@(posedge clk_sys) disable iff (reset) // RQ10
    stab_done
    |-> cpu_clk_en)
    else $error("done without cpu clock");

  AST_CTRL_KEEP: assert property (@(posedge clk_sys) disable iff (reset) // RQ1
    !wr_ctrl
    |=> $stable(ctrl_r))
    else $error("control changed without write");
endmodule
`default_nettype wire

// ===== tb/reset_loop.sv
`timescale 1ns/10ps
`default_nettype none
module reset_loop (
  input wire logic clk_sys,
  input wire logic por,
  input wire logic sys_reset_req,
  output logic reset
);
  // the watchdog request loops back as a four-cycle system reset
  logic [2:0] cnt_r;
  always_ff @(posedge clk_sys or posedge por) begin
    if (por) cnt_r <= 3'h0;
    else if (sys_reset_req) cnt_r <= 3'h4;
    else if (cnt_r != 3'h0) cnt_r <= cnt_r - 3'h1;
  end
  assign reset = por | (cnt_r != 3'h0);
endmodule
`default_nettype wire

// ===== tb/basic_watchdog_stabilizer_bench.sv
`timescale 1ns/10ps
`default_nettype none
module basic_watchdog_stabilizer_bench
  import wdt_pkg::*;
;
  logic clk_sys = 0, por = 1, stop_req = 0, wake_irq = 0;
  logic reset, tick_overflow, sys_reset_req, div_clear, cpu_clk_en, stab_done;
  logic [7:0] rdata, d;
  logic [7:0] e [3] = '{8'h03, 8'h0c, 8'h60};
  bus_req_t bus_req = '0;
  int n_mismatch = 0, cmp_count = 0, n;
  always #20 clk_sys = ~clk_sys;
  reset_loop i_reset_loop(.clk_sys(clk_sys), .por(por),
    .sys_reset_req(sys_reset_req), .reset(reset));
  basic_watchdog_stabilizer i_basic_watchdog_stabilizer(.clk_sys(clk_sys),
    .reset(reset), .bus_req(bus_req), .stop_req(stop_req),
    .wake_irq(wake_irq), .rdata(rdata), .tick_overflow(tick_overflow),
    .sys_reset_req(sys_reset_req), .div_clear(div_clear),
    .cpu_clk_en(cpu_clk_en), .stab_done(stab_done));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys) bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys) bus_req <= '0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk_sys) bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys) bus_req <= '0;
    #1 d = rdata;
  endtask
  task automatic waitfor(ref logic s, input int lim);
    n = 0;
    while (s !== 1'b1 && n < lim) begin
      @(posedge clk_sys);
      #1 n++;
    end
  endtask
  task end_of_test;
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #40_000_000;
    n_mismatch++;
    end_of_test;
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    por <= 1'b0;
    rd(ADDR_CONTROL); chk(d, CONTROL_RESET);
    wr(ADDR_CONTROL, 8'h01); #1 chk({7'h00, div_clear}, 8'h01);
    waitfor(cpu_clk_en, 600000);
    chk({7'h00, n > 520000 && n < 530000}, 8'h01);
    chk({7'h00, stab_done}, 8'h01);
    // rate of select codes 0, 1 and 2 from a cleared counter and prescaler
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_CONTROL, {4'ha, i[1:0], 2'b11});
      repeat (12287) @(posedge clk_sys);
      rd(ADDR_COUNT);
      chk({7'h00, d >= e[i] - 8'h01 && d <= e[i]}, 8'h01);
    end
    wr(ADDR_COUNT, 8'h00); rd(ADDR_COUNT);
    chk({7'h00, d > 8'h50}, 8'h01);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CONTROL, 8'h0a);
      repeat (20000) @(posedge clk_sys);
    end
    #1 chk({7'h00, cpu_clk_en}, 8'h01);
    wr(ADDR_CONTROL, 8'ha8);
    repeat (40000) @(posedge clk_sys);
    #1 chk({7'h00, cpu_clk_en}, 8'h01);
    @(posedge clk_sys) stop_req <= 1'b1;
    @(posedge clk_sys) stop_req <= 1'b0;
    repeat (10) @(posedge clk_sys);
    #1 chk({7'h00, cpu_clk_en}, 8'h00);
    @(posedge clk_sys) wake_irq <= 1'b1;
    repeat (4) @(posedge clk_sys);
    wake_irq <= 1'b0;
    waitfor(cpu_clk_en, 20000);
    chk({7'h00, n > 16000 && n < 16500}, 8'h01);
    chk({7'h00, stab_done}, 8'h01);
    wr(ADDR_CONTROL, 8'h0a);
    waitfor(sys_reset_req, 34000);
    chk({7'h00, n > 32000 && n < 33000}, 8'h01);
    chk({6'h00, tick_overflow, sys_reset_req}, 8'h03);
    repeat (8) @(posedge clk_sys);
    rd(ADDR_CONTROL); chk(d, CONTROL_RESET);
    chk({7'h00, cpu_clk_en}, 8'h00);
    end_of_test;
  end
endmodule
`default_nettype wire
